// ==== hw/sfc_defines.svh ====
// Address map, field positions, masks and scale constants of the stage setup block.
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// ---------------------------------------------------------------
// Address map (16-bit word addresses)
// ---------------------------------------------------------------
`define SFC_ADDR_W          10
`define SFC_STAGE_BASE      10'h080
`define SFC_STAGE_LAST      10'h0BF
`define SFC_WORD_ROUTE      3'h0
`define SFC_WORD_IN7        3'h1
`define SFC_WORD_OFFSET     3'h2
`define SFC_WORD_SENS       3'h3

// ---------------------------------------------------------------
// Writable bit masks, unused bits store and read as zero
// ---------------------------------------------------------------
`define SFC_MASK_ROUTE      16'h3FFF
`define SFC_MASK_IN7        16'hF003
`define SFC_MASK_OFFSET     16'hBFBF
`define SFC_MASK_SENS       16'h7F7F
`define SFC_RESET_WORD      16'h0000

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SFC_IN7_ROUTE_LSB   0
`define SFC_MEAS_LSB        12
`define SFC_NEG_OFF_DIS_BIT 14
`define SFC_POS_OFF_DIS_BIT 15
`define SFC_NEG_CODE_LSB    0
`define SFC_NEG_SWAP_BIT    7
`define SFC_POS_CODE_LSB    8
`define SFC_POS_SWAP_BIT    15
`define SFC_NEG_SENS_LSB    0
`define SFC_NEG_PEAK_LSB    4
`define SFC_POS_SENS_LSB    8
`define SFC_POS_PEAK_LSB    12

// ---------------------------------------------------------------
// Scale constants
// ---------------------------------------------------------------
`define SFC_OFFSET_STEP_FF  16'h0140
`define SFC_PEAK_BASE_PCT   7'h28
`define SFC_PEAK_STEP_PCT   7'h0A
`define SFC_PEAK_MAX_CODE   3'h5

`endif

// ==== hw/sfc_pkg.sv ====
// Types shared by the stage setup block.
package sfc_pkg;

  typedef enum logic [1:0] {
    SFC_ROUTE_OPEN = 2'b00,
    SFC_ROUTE_NEG  = 2'b01,
    SFC_ROUTE_POS  = 2'b10,
    SFC_ROUTE_BIAS = 2'b11
  } sfc_route_e;

  typedef enum logic [1:0] {
    SFC_MEAS_NONE = 2'b00,
    SFC_MEAS_SE_P = 2'b01,
    SFC_MEAS_SE_N = 2'b10,
    SFC_MEAS_DIFF = 2'b11
  } sfc_meas_e;

  typedef logic [2:0]  sfc_stage_t;
  typedef logic [15:0] sfc_word_t;

endpackage

// ==== hw/sfc_route_decode.sv ====
// Decoder from a two-bit sensor routing code to switch controls.
`timescale 1ns/10ps
`default_nettype none

module sfc_route_decode
  import sfc_pkg::*;
(
  // Routing code
  input  wire logic [1:0] code,
  // Switch controls
  output logic            to_neg,
  output logic            to_pos,
  output logic            to_bias
);

  always_comb begin
    to_neg  = 1'b0;
    to_pos  = 1'b0;
    to_bias = 1'b0;
    case (sfc_route_e'(code))
      SFC_ROUTE_NEG:  to_neg  = 1'b1;
      SFC_ROUTE_POS:  to_pos  = 1'b1;
      SFC_ROUTE_BIAS: to_bias = 1'b1;
      default: begin
      end
    endcase
  end

endmodule

`default_nettype wire

// ==== hw/sfc_level_lut.sv ====
// Lookup of threshold sensitivity and peak detect levels for one polarity.
`timescale 1ns/10ps
`default_nettype none

`include "sfc_defines.svh"

module sfc_level_lut
  import sfc_pkg::*;
(
  // Field codes
  input  wire logic [3:0]  sens_code,
  input  wire logic [2:0]  peak_code,
  // Levels, sensitivity in hundredths of a percent
  output logic      [13:0] sens_pct_x100,
  output logic      [6:0]  peak_pct,
  output logic             peak_bad
);

  always_comb begin
    case (sens_code)
      4'h0:    sens_pct_x100 = 14'd2500;
      4'h1:    sens_pct_x100 = 14'd2973;
      4'h2:    sens_pct_x100 = 14'd3440;
      4'h3:    sens_pct_x100 = 14'd3908;
      4'h4:    sens_pct_x100 = 14'd4379;
      4'h5:    sens_pct_x100 = 14'd4848;
      4'h6:    sens_pct_x100 = 14'd5315;
      4'h7:    sens_pct_x100 = 14'd5783;
      4'h8:    sens_pct_x100 = 14'd6251;
      4'h9:    sens_pct_x100 = 14'd6722;
      4'hA:    sens_pct_x100 = 14'd7190;
      4'hB:    sens_pct_x100 = 14'd7658;
      4'hC:    sens_pct_x100 = 14'd8128;
      4'hD:    sens_pct_x100 = 14'd8596;
      4'hE:    sens_pct_x100 = 14'd9064;
      default: sens_pct_x100 = 14'd9532;
    endcase
  end

  // Undefined peak codes give a zero level so they cannot pass for a real one.
  always_comb begin
    peak_bad = (peak_code > `SFC_PEAK_MAX_CODE);
    if (peak_bad) begin
      peak_pct = 7'h00;
    end else begin
      peak_pct = 7'(`SFC_PEAK_BASE_PCT + `SFC_PEAK_STEP_PCT * {4'h0, peak_code});
    end
  end

endmodule

`default_nettype wire

// ==== hw/sfc_stage_cfg.sv ====
// Per-stage front-end setup registers and decoded setup of the selected stage.
//
// Function
// - Input 7 code: open, negative, positive, bias
// - Measure type: SE positive, SE negative, differential
// - Input 7 word bit 14 set disables negative offset
// - Input 7 word bit 15 set disables positive offset
// - Negative offset code, 0.32 pF per step
// - Offset bit 7 swaps negative offset side
// - Positive offset code in bits 13:8
// - Offset bit 15 swaps positive offset side
// - Negative sensitivity table 25 to 95.32 percent
// - Negative peak level 40 to 90 percent
// - Positive sensitivity uses same table
// - Positive peak level 40 to 90 percent
// - Eight stages each hold words 0 to 3
// - Inputs 0 to 6 routed by pairs
// - Route7, offset, sensitivity follow first routing word
`timescale 1ns/10ps
`default_nettype none

`include "sfc_defines.svh"

module sfc_stage_cfg
  import sfc_pkg::*;
#(
  parameter int STAGES  = 8,
  parameter int INPUTS  = 8
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Register port, word addressed
  input  wire logic [`SFC_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [15:0]            reg_wdata,
  output logic      [15:0]            reg_rdata,
  output logic                        reg_rvalid,
  output logic                        reg_hit,
  // Sequencer stage select
  input  wire logic [2:0]             stage_sel,
  // Sensor switch matrix of the selected stage
  output logic      [INPUTS-1:0]      conn_neg,
  output logic      [INPUTS-1:0]      conn_pos,
  output logic      [INPUTS-1:0]      conn_bias,
  // Measurement type
  output logic      [1:0]             measure_type_sel,
  output logic                        measure_diff,
  output logic                        measure_type_bad,
  // Front-end offsets
  output logic                        neg_frontend_offset_off,
  output logic                        pos_frontend_offset_off,
  output logic      [5:0]             neg_frontend_offset_code,
  output logic      [5:0]             pos_frontend_offset_code,
  output logic                        neg_offset_side_swap,
  output logic                        pos_offset_side_swap,
  output logic      [15:0]            cap_neg_input_offset_ff,
  output logic      [15:0]            cap_pos_input_offset_ff,
  // Thresholds and peak levels
  output logic      [3:0]             neg_thresh_sens,
  output logic      [3:0]             pos_thresh_sens,
  output logic      [13:0]            neg_sens_pct_x100,
  output logic      [13:0]            pos_sens_pct_x100,
  output logic      [2:0]             neg_peak_level,
  output logic      [2:0]             pos_peak_level,
  output logic      [6:0]             neg_peak_pct,
  output logic      [6:0]             pos_peak_pct,
  output logic                        peak_code_bad
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  function automatic logic in_window(input logic [`SFC_ADDR_W-1:0] a);
    in_window = (a >= `SFC_STAGE_BASE) && (a <= `SFC_STAGE_LAST);
  endfunction

  function automatic sfc_stage_t stage_of(input logic [`SFC_ADDR_W-1:0] a);
    logic [`SFC_ADDR_W-1:0] rel;
    rel      = a - `SFC_STAGE_BASE;
    stage_of = rel[5:3];
  endfunction

  function automatic logic [15:0] offset_ff(input logic [5:0] code);
    offset_ff = 16'({10'h000, code} * `SFC_OFFSET_STEP_FF);
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------

  sfc_word_t route_mem [STAGES];
  sfc_word_t in7_mem   [STAGES];
  sfc_word_t offs_mem  [STAGES];
  sfc_word_t sens_mem  [STAGES];

  logic       acc_hit;
  sfc_stage_t acc_stage;
  logic [2:0] acc_word;

  assign acc_hit   = in_window(reg_addr);
  assign acc_stage = stage_of(reg_addr);
  assign acc_word  = reg_addr[2:0];

  // Masking on write keeps unused bits at zero even if the host breaks
  // its promise to write them as zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int s = 0; s < STAGES; s++) begin
        route_mem[s] <= `SFC_RESET_WORD;
        in7_mem[s]   <= `SFC_RESET_WORD;
        offs_mem[s]  <= `SFC_RESET_WORD;
        sens_mem[s]  <= `SFC_RESET_WORD;
      end
    end else if (reg_wr && acc_hit) begin
      case (acc_word)
        `SFC_WORD_ROUTE:  route_mem[acc_stage] <= reg_wdata & `SFC_MASK_ROUTE;
        `SFC_WORD_IN7:    in7_mem[acc_stage] <= reg_wdata & `SFC_MASK_IN7;
        `SFC_WORD_OFFSET: offs_mem[acc_stage] <= reg_wdata & `SFC_MASK_OFFSET;
        `SFC_WORD_SENS:   sens_mem[acc_stage] <= reg_wdata & `SFC_MASK_SENS;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------

  logic [15:0] next_rdata;

  // Words 4 to 7 of each stage live in other blocks and read as zero here.
  always_comb begin
    next_rdata = 16'h0000;
    if (acc_hit) begin
      case (acc_word)
        `SFC_WORD_ROUTE:  next_rdata = route_mem[acc_stage];
        `SFC_WORD_IN7:    next_rdata = in7_mem[acc_stage];
        `SFC_WORD_OFFSET: next_rdata = offs_mem[acc_stage];
        `SFC_WORD_SENS:   next_rdata = sens_mem[acc_stage];
        default:          next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
      reg_hit    <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_hit    <= reg_rd && acc_hit && (acc_word <= `SFC_WORD_SENS);
      reg_rdata  <= reg_rd ? next_rdata : 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Selected stage fields
  // ---------------------------------------------------------------

  sfc_word_t sel_route;
  sfc_word_t sel_in7;
  sfc_word_t sel_offs;
  sfc_word_t sel_sens;

  assign sel_route = route_mem[stage_sel];
  assign sel_in7   = in7_mem[stage_sel];
  assign sel_offs  = offs_mem[stage_sel];
  assign sel_sens  = sens_mem[stage_sel];

  logic [15:0] all_codes;

  assign all_codes = {sel_in7[`SFC_IN7_ROUTE_LSB +: 2], sel_route[13:0]};

  // ---------------------------------------------------------------
  // Switch matrix decode
  // ---------------------------------------------------------------

  logic [INPUTS-1:0] dec_neg;
  logic [INPUTS-1:0] dec_pos;
  logic [INPUTS-1:0] dec_bias;

  for (genvar i = 0; i < INPUTS; i++) begin : g_route
    sfc_route_decode u_dec (
      .code    (all_codes[2*i +: 2]),
      .to_neg  (dec_neg[i]),
      .to_pos  (dec_pos[i]),
      .to_bias (dec_bias[i])
    );
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conn_neg  <= '0;
      conn_pos  <= '0;
      conn_bias <= '0;
    end else begin
      conn_neg  <= dec_neg;
      conn_pos  <= dec_pos;
      conn_bias <= dec_bias;
    end
  end

  // ---------------------------------------------------------------
  // Measurement type
  // ---------------------------------------------------------------

  sfc_meas_e sel_meas;

  assign sel_meas = sfc_meas_e'(sel_in7[`SFC_MEAS_LSB +: 2]);

  // Code 00 is forbidden to the host; it is flagged rather than repaired.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      measure_type_sel <= 2'h0;
      measure_diff     <= 1'b0;
      measure_type_bad <= 1'b0;
    end else begin
      measure_type_sel <= sel_meas;
      measure_diff     <= (sel_meas == SFC_MEAS_DIFF);
      measure_type_bad <= (sel_meas == SFC_MEAS_NONE);
    end
  end

  // ---------------------------------------------------------------
  // Front-end offsets
  // ---------------------------------------------------------------

  logic        sel_neg_off;
  logic        sel_pos_off;
  logic        sel_neg_swap;
  logic        sel_pos_swap;
  logic [15:0] neg_ff;
  logic [15:0] pos_ff;

  assign sel_neg_off  = sel_in7[`SFC_NEG_OFF_DIS_BIT];
  assign sel_pos_off  = sel_in7[`SFC_POS_OFF_DIS_BIT];
  assign sel_neg_swap = sel_offs[`SFC_NEG_SWAP_BIT];
  assign sel_pos_swap = sel_offs[`SFC_POS_SWAP_BIT];
  assign neg_ff = sel_neg_off ? 16'h0000 : offset_ff(sel_offs[`SFC_NEG_CODE_LSB +: 6]);
  assign pos_ff = sel_pos_off ? 16'h0000 : offset_ff(sel_offs[`SFC_POS_CODE_LSB +: 6]);

  // Both offsets may land on one converter input; the sum stays in 16 bits.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      neg_frontend_offset_off  <= 1'b0;
      pos_frontend_offset_off  <= 1'b0;
      neg_frontend_offset_code <= 6'h00;
      pos_frontend_offset_code <= 6'h00;
      neg_offset_side_swap     <= 1'b0;
      pos_offset_side_swap     <= 1'b0;
      cap_neg_input_offset_ff  <= 16'h0000;
      cap_pos_input_offset_ff  <= 16'h0000;
    end else begin
      neg_frontend_offset_off  <= sel_neg_off;
      pos_frontend_offset_off  <= sel_pos_off;
      neg_frontend_offset_code <= sel_offs[`SFC_NEG_CODE_LSB +: 6];
      pos_frontend_offset_code <= sel_offs[`SFC_POS_CODE_LSB +: 6];
      neg_offset_side_swap     <= sel_neg_swap;
      pos_offset_side_swap     <= sel_pos_swap;
      cap_neg_input_offset_ff  <= (sel_neg_swap ? 16'h0000 : neg_ff)
                                  + (sel_pos_swap ? pos_ff : 16'h0000);
      cap_pos_input_offset_ff  <= (sel_neg_swap ? neg_ff : 16'h0000)
                                  + (sel_pos_swap ? 16'h0000 : pos_ff);
    end
  end

  // ---------------------------------------------------------------
  // Sensitivity and peak detect
  // ---------------------------------------------------------------

  logic [13:0] lut_neg_sens;
  logic [13:0] lut_pos_sens;
  logic [6:0]  lut_neg_peak;
  logic [6:0]  lut_pos_peak;
  logic        lut_neg_bad;
  logic        lut_pos_bad;

  sfc_level_lut u_neg_lut (
    .sens_code     (sel_sens[`SFC_NEG_SENS_LSB +: 4]),
    .peak_code     (sel_sens[`SFC_NEG_PEAK_LSB +: 3]),
    .sens_pct_x100 (lut_neg_sens),
    .peak_pct      (lut_neg_peak),
    .peak_bad      (lut_neg_bad)
  );

  sfc_level_lut u_pos_lut (
    .sens_code     (sel_sens[`SFC_POS_SENS_LSB +: 4]),
    .peak_code     (sel_sens[`SFC_POS_PEAK_LSB +: 3]),
    .sens_pct_x100 (lut_pos_sens),
    .peak_pct      (lut_pos_peak),
    .peak_bad      (lut_pos_bad)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      neg_thresh_sens   <= 4'h0;
      pos_thresh_sens   <= 4'h0;
      neg_sens_pct_x100 <= 14'h0000;
      pos_sens_pct_x100 <= 14'h0000;
      neg_peak_level    <= 3'h0;
      pos_peak_level    <= 3'h0;
      neg_peak_pct      <= 7'h00;
      pos_peak_pct      <= 7'h00;
      peak_code_bad     <= 1'b0;
    end else begin
      neg_thresh_sens   <= sel_sens[`SFC_NEG_SENS_LSB +: 4];
      pos_thresh_sens   <= sel_sens[`SFC_POS_SENS_LSB +: 4];
      neg_sens_pct_x100 <= lut_neg_sens;
      pos_sens_pct_x100 <= lut_pos_sens;
      neg_peak_level    <= sel_sens[`SFC_NEG_PEAK_LSB +: 3];
      pos_peak_level    <= sel_sens[`SFC_POS_PEAK_LSB +: 3];
      neg_peak_pct      <= lut_neg_peak;
      pos_peak_pct      <= lut_pos_peak;
      peak_code_bad     <= lut_neg_bad || lut_pos_bad;
    end
  end

endmodule

`default_nettype wire

// ==== dv/sfc_stage_cfg_checker.sv ====
// Concurrent checks on the ports of the stage setup block.
`timescale 1ns/10ps
`default_nettype none

module sfc_stage_cfg_checker
  import sfc_pkg::*;
(
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [9:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        reg_hit,
  input wire logic [2:0]  stage_sel,
  // Decoded setup of the selected stage
  input wire logic [1:0]  measure_type_sel,
  input wire logic        measure_diff,
  input wire logic        measure_type_bad,
  input wire logic        neg_frontend_offset_off,
  input wire logic        pos_frontend_offset_off,
  input wire logic [5:0]  neg_frontend_offset_code,
  input wire logic [5:0]  pos_frontend_offset_code,
  input wire logic        neg_offset_side_swap,
  input wire logic        pos_offset_side_swap,
  input wire logic [15:0] cap_neg_input_offset_ff,
  input wire logic [2:0]  neg_peak_level,
  input wire logic [2:0]  pos_peak_level,
  input wire logic [6:0]  neg_peak_pct,
  input wire logic [6:0]  pos_peak_pct,
  input wire logic        peak_code_bad
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic       in_map;
  logic [1:0] wr_meas;
  assign in_map  = (reg_addr[9:6] == 4'h2) && !reg_addr[2];
  assign wr_meas = reg_wdata[13:12];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_read_answer: assert property (reg_rd |=> reg_rvalid && reg_hit == $past(in_map))
    else $error("read answer missing or hit flag wrong");
  a_unmapped_read: assert property (reg_rd && !in_map |=> reg_rdata == 16'h0000 && !reg_hit)
    else $error("unmapped read returned data");
  a_measure_flags: assert property ($past(rst_n) |-> measure_diff == (measure_type_sel == 2'b11)
    && measure_type_bad == (measure_type_sel == 2'b00))
    else $error("measure type flags disagree with code");
  a_type_latency: assert property (reg_wr && reg_addr[2:0] == 3'h1 && reg_addr[9:6] == 4'h2
    && reg_addr[5:3] == stage_sel ##1 $stable(stage_sel) |=> measure_type_sel == $past(wr_meas, 2))
    else $error("written measure type not shown two edges later");
  a_neg_peak: assert property ($past(rst_n) && neg_peak_level <= 3'h5 |->
    neg_peak_pct == 7'h28 + 7'h0A * 7'(neg_peak_level))
    else $error("negative peak level wrong");
  a_pos_peak: assert property ($past(rst_n) && pos_peak_level <= 3'h5 |->
    pos_peak_pct == 7'h28 + 7'h0A * 7'(pos_peak_level))
    else $error("positive peak level wrong");
  a_peak_bad: assert property ($past(rst_n) |-> peak_code_bad ==
    (neg_peak_level > 3'h5 || pos_peak_level > 3'h5))
    else $error("undefined peak code flag wrong");
  a_offset_sum: assert property ($past(rst_n) |-> cap_neg_input_offset_ff ==
    ((neg_offset_side_swap || neg_frontend_offset_off) ? 16'h0000
      : 16'h0140 * 16'(neg_frontend_offset_code))
    + ((pos_offset_side_swap && !pos_frontend_offset_off)
      ? 16'h0140 * 16'(pos_frontend_offset_code) : 16'h0000))
    else $error("negative input offset total wrong");

  c_hit_read: cover property (reg_rd ##1 reg_hit);
  c_diff: cover property (measure_diff);
  c_peak_bad: cover property (peak_code_bad);
  c_both_neg: cover property (pos_offset_side_swap && cap_neg_input_offset_ff != 16'h0000);
endmodule

bind sfc_stage_cfg sfc_stage_cfg_checker sfc_stage_cfg_checker_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
  .stage_sel(stage_sel), .measure_type_sel(measure_type_sel), .measure_diff(measure_diff),
  .measure_type_bad(measure_type_bad), .neg_frontend_offset_off(neg_frontend_offset_off),
  .pos_frontend_offset_off(pos_frontend_offset_off),
  .neg_frontend_offset_code(neg_frontend_offset_code),
  .pos_frontend_offset_code(pos_frontend_offset_code),
  .neg_offset_side_swap(neg_offset_side_swap), .pos_offset_side_swap(pos_offset_side_swap),
  .cap_neg_input_offset_ff(cap_neg_input_offset_ff), .neg_peak_level(neg_peak_level),
  .pos_peak_level(pos_peak_level), .neg_peak_pct(neg_peak_pct), .pos_peak_pct(pos_peak_pct),
  .peak_code_bad(peak_code_bad)
);

`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the stage setup block.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ---------------------------------------------------------------
  // Stimulus, outputs and design
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  reg_addr = 10'h000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [2:0]  stage_sel = 3'h0;
  logic [15:0] reg_rdata, cap_neg_input_offset_ff, cap_pos_input_offset_ff;
  logic        reg_rvalid, reg_hit, measure_diff, measure_type_bad, peak_code_bad;
  logic [7:0]  conn_neg, conn_pos, conn_bias;
  logic [1:0]  measure_type_sel;
  logic        neg_frontend_offset_off, pos_frontend_offset_off;
  logic        neg_offset_side_swap, pos_offset_side_swap;
  logic [5:0]  neg_frontend_offset_code, pos_frontend_offset_code;
  logic [3:0]  neg_thresh_sens, pos_thresh_sens;
  logic [13:0] neg_sens_pct_x100, pos_sens_pct_x100;
  logic [2:0]  neg_peak_level, pos_peak_level;
  logic [6:0]  neg_peak_pct, pos_peak_pct;
  int          mismatches = 0;
  int          num_checks = 0;

  always #5 clk = ~clk;

  sfc_stage_cfg sfc_stage_cfg_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .stage_sel(stage_sel), .conn_neg(conn_neg), .conn_pos(conn_pos), .conn_bias(conn_bias),
    .measure_type_sel(measure_type_sel), .measure_diff(measure_diff),
    .measure_type_bad(measure_type_bad), .neg_frontend_offset_off(neg_frontend_offset_off),
    .pos_frontend_offset_off(pos_frontend_offset_off),
    .neg_frontend_offset_code(neg_frontend_offset_code),
    .pos_frontend_offset_code(pos_frontend_offset_code),
    .neg_offset_side_swap(neg_offset_side_swap), .pos_offset_side_swap(pos_offset_side_swap),
    .cap_neg_input_offset_ff(cap_neg_input_offset_ff),
    .cap_pos_input_offset_ff(cap_pos_input_offset_ff), .neg_thresh_sens(neg_thresh_sens),
    .pos_thresh_sens(pos_thresh_sens), .neg_sens_pct_x100(neg_sens_pct_x100),
    .pos_sens_pct_x100(pos_sens_pct_x100), .neg_peak_level(neg_peak_level),
    .pos_peak_level(pos_peak_level), .neg_peak_pct(neg_peak_pct), .pos_peak_pct(pos_peak_pct),
    .peak_code_bad(peak_code_bad)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] exp, input logic hit);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'({reg_rvalid, reg_hit}), 16'({1'b1, hit}));
    chk(reg_rdata, exp);
  endtask

  task automatic show(input logic [2:0] s);
    @(posedge clk);
    stage_sel <= s;
    repeat (2) @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] pk(input logic [2:0] k);
    return (k > 3'h5) ? 16'h0000 : 16'h0028 + 16'h000A * 16'(k);
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    show(3'h0);
    chk(16'(measure_type_bad), 16'h0001);
    chk(16'(neg_sens_pct_x100), 16'h09C4);
    chk(16'({neg_peak_pct, pos_peak_pct}), 16'h1428);
  endtask

  task automatic t_regs();
    logic [9:0]  a;
    logic [15:0] m;
    for (int s = 0; s < 8; s++) begin
      for (int w = 0; w < 8; w++) begin
        a = 10'(10'h080 + 8 * s + w);
        m = (w == 0) ? 16'h3FFF : (w == 1) ? 16'hF003 : (w == 2) ? 16'hBFBF
          : (w == 3) ? 16'h7F7F : 16'h0000;
        rd(a, 16'h0000, w < 4);
        wr(a, 16'hFFFF);
        rd(a, m, w < 4);
      end
    end
    for (int s = 0; s < 8; s++) wr(10'(10'h082 + 8 * s), {8'(s), 8'(s)});
    for (int s = 0; s < 8; s++) rd(10'(10'h082 + 8 * s), {8'(s), 8'(s)}, 1'b1);
    wr(10'h07F, 16'hFFFF);
    rd(10'h07F, 16'h0000, 1'b0);
    wr(10'h0C0, 16'hFFFF);
    rd(10'h0C0, 16'h0000, 1'b0);
  endtask

  task automatic t_route();
    logic [15:0] r0;
    logic [1:0]  c;
    logic [7:0]  en, ep, eb;
    for (int m = 0; m < 4; m++) begin
      r0 = 16'h0000;
      for (int i = 0; i < 7; i++) r0[2*i +: 2] = 2'(i + m);
      wr(10'h0A8, r0);
      wr(10'h0A9, {2'b00, 2'(m), 10'h000, 2'(m + 7)});
      show(3'h5);
      for (int i = 0; i < 8; i++) begin
        c = 2'(i + m);
        en[i] = (c == 2'b01);
        ep[i] = (c == 2'b10);
        eb[i] = (c == 2'b11);
      end
      chk(16'(conn_neg), 16'(en));
      chk(16'(conn_pos), 16'(ep));
      chk(16'(conn_bias), 16'(eb));
      chk(16'({measure_diff, measure_type_bad, measure_type_sel}),
          16'({m == 3, m == 0, 2'(m)}));
    end
  endtask

  task automatic t_offset();
    logic [15:0] n, p;
    for (int d = 0; d < 4; d++) begin
      for (int sw = 0; sw < 4; sw++) begin
        wr(10'h0B9, {2'(d), 2'b11, 12'h000});
        wr(10'h0BA, {sw[1], 1'b0, 6'h2A, sw[0], 1'b0, 6'h3F});
        show(3'h7);
        n = d[0] ? 16'h0000 : 16'h0140 * 16'h003F;
        p = d[1] ? 16'h0000 : 16'h0140 * 16'h002A;
        chk(cap_neg_input_offset_ff, (sw[0] ? 16'h0000 : n) + (sw[1] ? p : 16'h0000));
        chk(cap_pos_input_offset_ff, (sw[0] ? n : 16'h0000) + (sw[1] ? 16'h0000 : p));
        chk(16'({pos_frontend_offset_off, neg_frontend_offset_off, pos_offset_side_swap,
                 neg_offset_side_swap}), 16'({2'(d), 2'(sw)}));
        chk({2'b00, pos_frontend_offset_code, 2'b00, neg_frontend_offset_code}, 16'h2A3F);
      end
    end
  endtask

  task automatic t_sens();
    logic [15:0] tbl [16] = '{16'h09C4, 16'h0B9D, 16'h0D70, 16'h0F44, 16'h111B, 16'h12F0,
      16'h14C3, 16'h1697, 16'h186B, 16'h1A42, 16'h1C16, 16'h1DEA, 16'h1FC0, 16'h2194,
      16'h2368, 16'h253C};
    logic [2:0]  a, b;
    for (int c = 0; c < 16; c++) begin
      a = 3'(c);
      b = 3'(c + 3);
      wr(10'h0A3, {1'b0, b, 4'(15 - c), 1'b0, a, 4'(c)});
      show(3'h4);
      chk(16'(neg_sens_pct_x100), tbl[c]);
      chk(16'(pos_sens_pct_x100), tbl[15-c]);
      chk(16'(neg_peak_pct), pk(a));
      chk(16'(pos_peak_pct), pk(b));
      chk(16'({peak_code_bad, neg_peak_level, pos_peak_level, neg_thresh_sens, pos_thresh_sens}),
          16'({a > 3'h5 || b > 3'h5, a, b, 4'(c), 4'(15 - c)}));
    end
  endtask

  // A read in the cycle of a write to its word returns the old word.
  task automatic t_b2b();
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= 10'h093;
    reg_wdata <= 16'h1234;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_wdata <= 16'h0055;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    chk(reg_rdata, 16'h1234);
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 16'h0055);
    @(posedge clk);
    #1;
    chk(reg_rdata | 16'(reg_rvalid), 16'h0000);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_route();
    t_offset();
    t_sens();
    t_b2b();
    final_report();
  end

  // The run needs about 700 cycles; the limit allows ten times that.
  initial begin
    #75000;
    mismatches++;
    final_report();
  end
endmodule

`default_nettype wire
